// >>> logic/rrs_consts.svh
`ifndef RRS_CONSTS_SVH
`define RRS_CONSTS_SVH
// Opcode field positions and widths
`define RRS_OP_W 14
`define RRS_PC_W 13
`define RRS_DW 8
`define RRS_FA_W 7
`define RRS_DEPTH 8
`define RRS_SP_W 3
// Decoded instruction words (14-bit)
`define RRS_OPC_IDLE 14'h0000
`define RRS_OPC_RETI 14'h0009
`define RRS_OPC_RET 14'h0008
`define RRS_HI_RETK 4'hD
`define RRS_HI_ROTL 6'h0D
`define RRS_RETK_LSB 10
`define RRS_ROTL_LSB 8
`define RRS_PC_STEP 13'h0001
// Field positions
`define RRS_DSEL_BIT 7
`define RRS_GIE_BIT 7
`define RRS_ZERO_PC 13'h0000
`define RRS_ZERO_BYTE 8'h00
`define RRS_ZERO_SP 3'h0
`define RRS_ONE_SP 3'h1
`endif

// >>> logic/rrs_pkg.sv
package rrs_pkg;
    typedef enum logic [2:0] {
        RRS_NONE = 3'h0,
        RRS_IDLE = 3'h1,
        RRS_RETI = 3'h3,
        RRS_RET = 3'h2,
        RRS_RETK = 3'h6,
        RRS_ROTL = 3'h7
    } rrs_op_e;
    typedef enum logic {
        RRS_S_FIRST = 1'b0,
        RRS_S_SECOND = 1'b1
    } rrs_state_e;
endpackage : rrs_pkg

// >>> logic/rrs_decode.sv
`include "rrs_consts.svh"
module rrs_decode
    import rrs_pkg::*;
(
    // Instruction word in, operation out
    input wire logic [`RRS_OP_W-1:0] instr,
    output rrs_op_e op
);
    // Match the subset opcodes
    always_comb begin
        op = RRS_NONE;
        if (instr == `RRS_OPC_IDLE) begin
            op = RRS_IDLE;
        end else if (instr == `RRS_OPC_RETI) begin
            op = RRS_RETI;
        end else if (instr == `RRS_OPC_RET) begin
            op = RRS_RET;
        end else if (instr[`RRS_OP_W-1:`RRS_RETK_LSB] == `RRS_HI_RETK) begin
            op = RRS_RETK;
        end else if (instr[`RRS_OP_W-1:`RRS_ROTL_LSB] == `RRS_HI_ROTL) begin
            op = RRS_ROTL;
        end
    end
endmodule : rrs_decode

// >>> logic/rrs_core.sv
`include "rrs_consts.svh"
// Summary of operation
// - Return from interrupt pops stack into program counter over two cycles.
// - Return from interrupt also sets global_irq_enable.
// - Subroutine return pops stack into program counter, two cycles, flags untouched.
// - Return with immediate loads literal to accumulator, pops PC, two cycles.
// - Rotate left shifts operand up; old carry in, old top bit out.
// - Select 0 writes accumulator only; select 1 writes back the source register.
module rrs_core
    import rrs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [`RRS_OP_W-1:0] instr,
    // Stack push from call or interrupt entry
    input wire logic push_en,
    input wire logic [`RRS_PC_W-1:0] push_addr,
    // Register file read data for the addressed operand
    input wire logic [`RRS_DW-1:0] file_rdata,
    // Status
    output logic busy,
    output logic [`RRS_PC_W-1:0] pc,
    output logic [`RRS_DW-1:0] acc,
    output logic carry,
    output logic global_irq_enable,
    output logic [`RRS_SP_W-1:0] stack_ptr,
    // Register file write
    output logic file_we,
    output logic [`RRS_FA_W-1:0] file_addr,
    output logic [`RRS_DW-1:0] file_wdata
);
    ////////////////////////////////////////////////////////////////////////
    rrs_op_e op;
    rrs_state_e state_q;
    logic [`RRS_PC_W-1:0] stack_q [`RRS_DEPTH];
    logic [`RRS_SP_W-1:0] sp_q;
    logic [`RRS_PC_W-1:0] pc_q;
    logic [`RRS_DW-1:0] acc_q;
    logic carry_q;
    logic gie_q;
    logic fwe_q;
    logic [`RRS_FA_W-1:0] faddr_q;
    logic [`RRS_DW-1:0] fwdata_q;
    logic [`RRS_DW-1:0] rot_d;
    logic [`RRS_SP_W-1:0] top_idx;
    logic start;
    logic is_return;

    rrs_decode u_dec (
        .instr(instr),
        .op(op)
    );

    // Accepted only when not in the second cycle
    assign start = instr_valid && (state_q == RRS_S_FIRST);
    assign is_return = (op == RRS_RETI) || (op == RRS_RET) || (op == RRS_RETK);
    assign top_idx = sp_q - `RRS_ONE_SP;
    assign rot_d = {file_rdata[`RRS_DW-2:0], carry_q};

    ////////////////////////////////////////////////////////////////////////
    // Two-cycle sequencer for returns
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= RRS_S_FIRST;
        end else begin
            unique case (state_q)
                RRS_S_FIRST: begin
                    if (start && is_return) begin
                        state_q <= RRS_S_SECOND;
                    end
                end
                RRS_S_SECOND: begin
                    state_q <= RRS_S_FIRST;
                end
            endcase
        end
    end

    // Stack storage, pushed by the surrounding core
    always_ff @(posedge clk) begin
        // Push loses to a same-cycle pop
        if (push_en && !(start && is_return)) begin
            stack_q[sp_q] <= push_addr;
        end
    end

    // Stack pointer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sp_q <= `RRS_ZERO_SP;
        end else if (start && is_return) begin
            sp_q <= top_idx;
        end else if (push_en) begin
            sp_q <= sp_q + `RRS_ONE_SP;
        end
    end

    // Program counter
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pc_q <= `RRS_ZERO_PC;
        end else if (start && is_return) begin
            pc_q <= stack_q[top_idx];
        end else if (start) begin
            pc_q <= pc_q + `RRS_PC_STEP;
        end
    end

    // Accumulator
    always_ff @(posedge clk) begin
        if (!resetn) begin
            acc_q <= `RRS_ZERO_BYTE;
        end else if (start && op == RRS_RETK) begin
            acc_q <= instr[`RRS_DW-1:0];
        end else if (start && op == RRS_ROTL && !instr[`RRS_DSEL_BIT]) begin
            acc_q <= rot_d;
        end
    end

    // Carry flag
    always_ff @(posedge clk) begin
        if (!resetn) begin
            carry_q <= 1'b0;
        end else if (start && op == RRS_ROTL) begin
            carry_q <= file_rdata[`RRS_DW-1];
        end
    end

    // Global interrupt enable
    always_ff @(posedge clk) begin
        if (!resetn) begin
            gie_q <= 1'b0;
        end else if (start && op == RRS_RETI) begin
            gie_q <= 1'b1;
        end
    end

    // Register file write back
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fwe_q <= 1'b0;
            faddr_q <= `RRS_FA_W'(0);
            fwdata_q <= `RRS_ZERO_BYTE;
        end else begin
            fwe_q <= start && op == RRS_ROTL && instr[`RRS_DSEL_BIT];
            faddr_q <= instr[`RRS_FA_W-1:0];
            fwdata_q <= rot_d;
        end
    end

    // Outputs straight from flip-flops
    assign busy = state_q;
    assign pc = pc_q;
    assign acc = acc_q;
    assign carry = carry_q;
    assign global_irq_enable = gie_q;
    assign stack_ptr = sp_q;
    assign file_we = fwe_q;
    assign file_addr = faddr_q;
    assign file_wdata = fwdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_ret_two_cycle: assert property (@(posedge clk) disable iff (!resetn)
        (start && is_return) |=> busy ##1 !busy)
        else $error("return not two cycles");
    chk_reti_pc_load: assert property (@(posedge clk) disable iff (!resetn)
        (start && op == RRS_RETI) |=> pc_q == $past(stack_q[top_idx]))
        else $error("pc not loaded from stack top");
    chk_reti_gie_set: assert property (@(posedge clk) disable iff (!resetn)
        (start && op == RRS_RETI) |=> gie_q)
        else $error("interrupt enable not set");
    chk_ret_flags_kept: assert property (@(posedge clk) disable iff (!resetn)
        (start && op == RRS_RET) |=> $stable(carry_q) && $stable(acc_q) && busy)
        else $error("return altered flags");
    chk_retk_acc: assert property (@(posedge clk) disable iff (!resetn)
        (start && op == RRS_RETK) |=> acc_q == $past(instr[`RRS_DW-1:0]) && $stable(carry_q))
        else $error("literal not in accumulator");
    chk_rotl_carry: assert property (@(posedge clk) disable iff (!resetn)
        (start && op == RRS_ROTL) |=> carry_q == $past(file_rdata[`RRS_DW-1]))
        else $error("carry wrong after rotate");
    chk_rotl_acc_dest: assert property (@(posedge clk) disable iff (!resetn)
        (start && op == RRS_ROTL && !instr[`RRS_DSEL_BIT]) |=>
        acc_q == {$past(file_rdata[`RRS_DW-2:0]), $past(carry_q)} && !file_we)
        else $error("rotate to accumulator wrong");
    chk_rotl_file_dest: assert property (@(posedge clk) disable iff (!resetn)
        (start && op == RRS_ROTL && instr[`RRS_DSEL_BIT]) |=> file_we && $stable(acc_q))
        else $error("rotate write back wrong");
    chk_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
        (start && op == RRS_IDLE && !push_en) |=>
        pc_q == $past(pc_q) + `RRS_PC_STEP && $stable(acc_q) && $stable(carry_q) && !busy)
        else $error("idle changed state");
    // Sequencing and side effects
    chk_busy_holds_pc: assert property (@(posedge clk) disable iff (!resetn)
        busy |=> $stable(pc_q) && $stable(acc_q) && !busy)
        else $error("state moved in second cycle");
    chk_ret_sp_pop: assert property (@(posedge clk) disable iff (!resetn)
        (start && is_return) |=> stack_ptr == $past(sp_q) - `RRS_ONE_SP)
        else $error("stack not popped on return");
    chk_rotl_wdata: assert property (@(posedge clk) disable iff (!resetn)
        (start && op == RRS_ROTL && instr[`RRS_DSEL_BIT]) |=>
        file_wdata == {$past(file_rdata[`RRS_DW-2:0]), $past(carry_q)})
        else $error("rotate write data wrong");
    chk_idle_no_side: assert property (@(posedge clk) disable iff (!resetn)
        (start && op == RRS_IDLE && !push_en) |=> !file_we && $stable(sp_q) && $stable(gie_q))
        else $error("idle caused a side effect");
endmodule : rrs_core

// >>> verification/tb_rrs_core.sv
`include "rrs_consts.svh"
module tb_rrs_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic instr_valid = 1'b0;
    logic [`RRS_OP_W-1:0] instr = `RRS_OPC_IDLE;
    logic push_en = 1'b0;
    logic [`RRS_PC_W-1:0] push_addr = `RRS_ZERO_PC;
    logic [`RRS_DW-1:0] file_rdata = `RRS_ZERO_BYTE;
    logic busy, carry, global_irq_enable, file_we;
    logic [`RRS_PC_W-1:0] pc;
    logic [`RRS_DW-1:0] acc, file_wdata;
    logic [`RRS_SP_W-1:0] stack_ptr;
    logic [`RRS_FA_W-1:0] file_addr;
    int miscompares = 0;
    int samples_checked = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 125 MHz
    always #4 clk = ~clk;
    rrs_core DUT (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
        .push_en(push_en), .push_addr(push_addr), .file_rdata(file_rdata), .busy(busy),
        .pc(pc), .acc(acc), .carry(carry), .global_irq_enable(global_irq_enable),
        .stack_ptr(stack_ptr), .file_we(file_we), .file_addr(file_addr),
        .file_wdata(file_wdata));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare one value and count it
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Issue one instruction, settle after the taking edge
    task automatic issue(input logic [`RRS_OP_W-1:0] w, input logic [`RRS_DW-1:0] rd);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= w;
        file_rdata <= rd;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask : issue
    // Push one return address
    task automatic push(input logic [`RRS_PC_W-1:0] a);
        @(posedge clk);
        push_en <= 1'b1;
        push_addr <= a;
        @(posedge clk);
        push_en <= 1'b0;
        #1;
    endtask : push
    // Verdict and end of run
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    // Idle advances pc only
    task automatic test_idle();
        issue(`RRS_OPC_IDLE, 8'hff);
        check("pc", 16'(pc), 16'h0001);
        check("acc carry sp", {acc, 3'h0, carry, 1'b0, stack_ptr}, 16'h0000);
        check("gie we", {global_irq_enable, file_we}, 16'h0000);
        $display("test idle done");
    endtask : test_idle
    // Rotate into accumulator, then back into the file
    task automatic test_rotate();
        issue({`RRS_HI_ROTL, 1'b0, 7'h11}, 8'he6);
        check("acc", 16'(acc), 16'h00cc);
        check("carry", 16'(carry), 16'h0001);
        check("no write", 16'(file_we), 16'h0000);
        issue({`RRS_HI_ROTL, 1'b1, 7'h25}, 8'h81);
        check("wdata", 16'(file_wdata), 16'h0003);
        check("we addr", {file_we, 8'h00, file_addr}, 16'h8025);
        check("carry", 16'(carry), 16'h0001);
        check("acc kept", 16'(acc), 16'h00cc);
        $display("test rotate done");
    endtask : test_rotate
    // Subroutine and immediate returns pop in order
    task automatic test_returns();
        push(13'h0123);
        push(13'h0456);
        issue(`RRS_OPC_RET, 8'h00);
        check("pc", 16'(pc), 16'h0456);
        check("sp busy", {stack_ptr, busy}, 16'h0003);
        check("carry gie", {carry, global_irq_enable}, 16'h0002);
        check("we pulse", 16'(file_we), 16'h0000);
        @(posedge clk);
        #1;
        check("busy end", 16'(busy), 16'h0000);
        issue({`RRS_HI_RETK, 2'b00, 8'ha5}, 8'h00);
        check("acc", 16'(acc), 16'h00a5);
        check("pc", 16'(pc), 16'h0123);
        check("sp busy carry", {stack_ptr, busy, carry}, 16'h0003);
        @(posedge clk);
        $display("test returns done");
    endtask : test_returns
    // Interrupt return sets global enable
    task automatic test_reti();
        push(13'h1abc);
        check("gie before", 16'(global_irq_enable), 16'h0000);
        issue(`RRS_OPC_RETI, 8'h00);
        check("pc", 16'(pc), 16'h1abc);
        check("gie", 16'(global_irq_enable), 16'h0001);
        check("sp busy", {stack_ptr, busy}, 16'h0001);
        @(posedge clk);
        #1;
        check("busy end", 16'(busy), 16'h0000);
        $display("test reti done");
    endtask : test_reti
    // Mid-run reset clears state, then idle advances from zero
    task automatic test_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1;
        check("reset pc flags", {pc, busy, carry, global_irq_enable}, 16'h0000);
        check("reset sp we acc", {stack_ptr, file_we, 4'h0, acc}, 16'h0000);
        issue(`RRS_OPC_IDLE, 8'h00);
        check("pc after reset", 16'(pc), 16'h0001);
        $display("test reset done");
    endtask : test_reset
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        #1;
        check("reset pc acc", {pc, 3'h0} | 16'(acc), 16'h0000);
        check("reset flags", {stack_ptr, busy, carry, global_irq_enable, file_we}, 16'h0000);
        test_idle();
        test_rotate();
        test_returns();
        test_reti();
        test_reset();
        results();
    end
    // Watchdog
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        results();
    end
endmodule : tb_rrs_core
